// ===== design/iwrb_pkg.sv
/*
  constants of the serial wiper register bank: map, fields, reset values,
  timing counts and the serial engine states.
  assumes a 25 MHz system clock.
*/
package iwrb_pkg;
  localparam int CLK_MHZ = 25;
  // register pointers as sent in the address byte
  localparam logic [7:0] ADDR_WIPER = 8'h00;
  localparam logic [7:0] ADDR_RSVD = 8'h01;
  localparam logic [7:0] ADDR_ACCESS = 8'h02;
  // access_control field positions
  localparam int ACR_VOL_BIT = 7;
  localparam int ACR_POWER_DOWN_N_BIT = 6;
  localparam int ACR_WIP_BIT = 5;
  // reset values
  localparam logic [6:0] WIPER_PRESET = 7'h40;
  localparam logic VOL_RESET = 1'b0;
  localparam logic POWER_DOWN_N_RESET = 1'b1;
  localparam logic [7:0] IVR_FACTORY = 8'h10;
  // top five bits of the identification byte
  localparam logic [4:0] DEV_ID_HI = 5'h0a;
  // self-timed non-volatile write, longest time rounded down
  localparam int NV_WRITE_MS = 20;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_MHZ * 1000;
  // supply settle time before the recall read
  localparam int RECALL_NS = 640;
  localparam int RECALL_CYC = (RECALL_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ID = 5'b00010,
    ST_REG = 5'b00100,
    ST_WR = 5'b01000,
    ST_RD = 5'b10000
  } iwrb_state_t;
endpackage : iwrb_pkg

// ===== design/iwrb_top.sv
/*
  serial-slave register bank of a single wiper potentiometer: wiper,
  stored initial value, access control, recall and shutdown.
  assumes an external master clocking the two-wire bus, pull-ups on both
  wires, and arst_n asserted only at power-up.
*/
`timescale 1ns/1ps
`default_nettype none
module iwrb_top #(
  parameter int unsigned NV_WRITE_CYC = iwrb_pkg::NV_WRITE_CYC, // store cycle length
  parameter logic [7:0] IVR_FACTORY = iwrb_pkg::IVR_FACTORY // store content at power-up
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // power-up reset
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // data pin drive value
  output logic sda_oe_n, // data pin enable, low drives
  input wire logic addr_pin_high, // address pin, upper
  input wire logic addr_pin_low, // address pin, lower
  input wire logic power_down_n, // shutdown pin
  output logic [6:0] wiper_tap, // selected tap
  output logic array_open, // array end to end open
  output logic wiper_grounded, // wiper tied to ground
  output logic nv_write_pending // store cycle running
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; bit 0 is read only by bit 1
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic [1:0] a1_q;
  logic [1:0] a0_q;
  logic [1:0] pd_q;
  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      a1_q <= 2'h0;
      a0_q <= 2'h0;
      pd_q <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_q <= {scl_q[0], scl_in};
      sda_q <= {sda_q[0], sda_in};
      a1_q <= {a1_q[0], addr_pin_high};
      a0_q <= {a0_q[0], addr_pin_low};
      pd_q <= {pd_q[0], power_down_n};
      scl_d_r <= scl_q[1];
      sda_d_r <= sda_q[1];
    end
  end
  wire scl_rise = scl_q[1] & ~scl_d_r;
  wire scl_fall = ~scl_q[1] & scl_d_r;
  wire start_det = scl_q[1] & scl_d_r & sda_d_r & ~sda_q[1];
  wire stop_det = scl_q[1] & scl_d_r & ~sda_d_r & sda_q[1];
  ////////////////////////////////////////////////////////////////////////
  // power-up: preset, then recall once the supply has settled
  localparam int RCW = 8;
  localparam logic [RCW-1:0] RECALL_LAST = RCW'(iwrb_pkg::RECALL_CYC - 1);
  logic [RCW-1:0] pu_cnt_r;
  logic pu_busy_r;
  wire recall_now = pu_busy_r & (pu_cnt_r == RECALL_LAST);
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pu_cnt_r <= '0;
      pu_busy_r <= 1'b1;
    end
    else if (pu_busy_r)
    begin
      pu_cnt_r <= pu_cnt_r + 1'b1;
      pu_busy_r <= ~recall_now;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // serial engine
  iwrb_pkg::iwrb_state_t state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic ack_ph_r, ack_ph_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic drive_r, drive_nxt;
  logic rw_r, rw_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic nack_r, nack_nxt;
  logic [6:0] wiper_r;
  logic [7:0] ivr_r;
  logic [7:0] ivr_pend_r;
  logic nv_arm_r;
  logic vol_r;
  logic power_down_n_r;
  logic wip_r;
  logic [31:0] nv_cnt_r;
  logic shut_r;
  wire byte_end = scl_fall & (bit_cnt_r == 4'h8) & ~ack_ph_r;
  wire ack_end = scl_fall & ack_ph_r;
  wire id_match = rx_r[7:1] == {iwrb_pkg::DEV_ID_HI, a1_q[1], a0_q[1]};
  wire at_wiper = ptr_r == iwrb_pkg::ADDR_WIPER;
  wire at_access = ptr_r == iwrb_pkg::ADDR_ACCESS;
  // writes lock out while a store cycle runs
  wire wr_ok = (state_r == iwrb_pkg::ST_WR) & byte_end & ~wip_r;
  wire wr_vol = wr_ok & at_wiper & vol_r;
  wire wr_ivr = wr_ok & at_wiper & ~vol_r;
  wire wr_acr = wr_ok & at_access;
  wire [7:0] acr_img = {vol_r, power_down_n_r, wip_r, 5'h00};
  wire [7:0] wiper_img = vol_r ? {1'b0, wiper_r} : ivr_r;
  wire [7:0] rd_data = at_wiper ? wiper_img : at_access ? acr_img : 8'h00;
  always_comb
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    ack_ph_nxt = ack_ph_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    drive_nxt = drive_r;
    rw_nxt = rw_r;
    ptr_nxt = ptr_r;
    nack_nxt = nack_r;
    // a start during power-up is not seen
    if (start_det & ~pu_busy_r)
    begin
      state_nxt = iwrb_pkg::ST_ID;
      bit_cnt_nxt = 4'h0;
      ack_ph_nxt = 1'b0;
      drive_nxt = 1'b0;
    end
    else if (stop_det)
    begin
      state_nxt = iwrb_pkg::ST_IDLE;
      bit_cnt_nxt = 4'h0;
      ack_ph_nxt = 1'b0;
      drive_nxt = 1'b0;
    end
    else if (state_r != iwrb_pkg::ST_IDLE)
    begin
      if (scl_rise & ~ack_ph_r & (bit_cnt_r != 4'h8))
      begin
        rx_nxt = {rx_r[6:0], sda_q[1]};
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end
      if (scl_rise & ack_ph_r)
        nack_nxt = sda_q[1];
      if (byte_end)
      begin
        ack_ph_nxt = 1'b1;
        drive_nxt = 1'b0;
        unique case (state_r)
          iwrb_pkg::ST_ID:
          begin
            rw_nxt = rx_r[0];
            drive_nxt = id_match;
            if (!id_match)
              state_nxt = iwrb_pkg::ST_IDLE;
          end
          iwrb_pkg::ST_REG:
          begin
            ptr_nxt = rx_r;
            drive_nxt = 1'b1;
          end
          iwrb_pkg::ST_WR:
            drive_nxt = 1'b1;
          iwrb_pkg::ST_RD:
            drive_nxt = 1'b0;
          iwrb_pkg::ST_IDLE:
            drive_nxt = 1'b0;
        endcase
      end
      else if (ack_end)
      begin
        ack_ph_nxt = 1'b0;
        bit_cnt_nxt = 4'h0;
        drive_nxt = 1'b0;
        unique case (state_r)
          iwrb_pkg::ST_ID:
          begin
            if (rw_r)
            begin
              state_nxt = iwrb_pkg::ST_RD;
              tx_nxt = rd_data;
              drive_nxt = ~rd_data[7];
            end
            else
              state_nxt = iwrb_pkg::ST_REG;
          end
          iwrb_pkg::ST_REG:
            state_nxt = iwrb_pkg::ST_WR;
          // only one data byte per write is taken
          iwrb_pkg::ST_WR:
            state_nxt = iwrb_pkg::ST_IDLE;
          iwrb_pkg::ST_RD:
          begin
            if (!nack_r)
            begin
              tx_nxt = rd_data;
              drive_nxt = ~rd_data[7];
            end
            else
              state_nxt = iwrb_pkg::ST_IDLE;
          end
          iwrb_pkg::ST_IDLE:
            state_nxt = iwrb_pkg::ST_IDLE;
        endcase
      end
      else if (scl_fall & (state_r == iwrb_pkg::ST_RD))
      begin
        tx_nxt = {tx_r[6:0], 1'b0};
        drive_nxt = ~tx_r[6];
      end
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= iwrb_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      drive_r <= 1'b0;
      rw_r <= 1'b0;
      ptr_r <= 8'h00;
      nack_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      ack_ph_r <= ack_ph_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      drive_r <= drive_nxt;
      rw_r <= rw_nxt;
      ptr_r <= ptr_nxt;
      nack_r <= nack_nxt;
    end
  end
  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_r;
  ////////////////////////////////////////////////////////////////////////
  // register bank and self-timed store cycle; store written at stop
  wire nv_start = stop_det & nv_arm_r;
  wire nv_done = wip_r & (nv_cnt_r == NV_WRITE_CYC - 1);
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wiper_r <= iwrb_pkg::WIPER_PRESET;
      ivr_r <= IVR_FACTORY;
      ivr_pend_r <= 8'h00;
      nv_arm_r <= 1'b0;
      vol_r <= iwrb_pkg::VOL_RESET;
      power_down_n_r <= iwrb_pkg::POWER_DOWN_N_RESET;
    end
    else
    begin
      if (recall_now)
        wiper_r <= ivr_r[6:0];
      else if (wr_vol | wr_ivr)
        wiper_r <= rx_r[6:0];
      if (wr_ivr)
      begin
        ivr_pend_r <= rx_r;
        nv_arm_r <= 1'b1;
      end
      else if (nv_start)
        nv_arm_r <= 1'b0;
      if (nv_start)
        ivr_r <= ivr_pend_r;
      if (wr_acr)
      begin
        vol_r <= rx_r[iwrb_pkg::ACR_VOL_BIT];
        power_down_n_r <= rx_r[iwrb_pkg::ACR_POWER_DOWN_N_BIT];
      end
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wip_r <= 1'b0;
      nv_cnt_r <= 32'h0;
    end
    else
    begin
      wip_r <= nv_start | (wip_r & ~nv_done);
      nv_cnt_r <= wip_r ? nv_cnt_r + 32'h1 : 32'h0;
    end
  end
  assign nv_write_pending = wip_r;
  // shutdown; the serial engine above ignores it entirely
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      shut_r <= 1'b0;
    else
      shut_r <= ~pd_q[1] | ~power_down_n_r;
  end
  assign array_open = shut_r;
  assign wiper_grounded = shut_r;
  // tap code stays in the wiper register while shut down
  assign wiper_tap = wiper_r;
endmodule : iwrb_top
`default_nettype wire

// ===== verification/iwrb_assertions.sv
/*
  pin-level checker of the wiper bank, bound into iwrb_top.
  assumes one clock domain with arst_n as its reset.
*/
`timescale 1ns/1ps
`default_nettype none
module iwrb_chk #(
  parameter int unsigned NV_WRITE_CYC = 2000, // store cycle
  parameter logic [7:0] IVR_FACTORY = 8'h10 // store at reset
) (
  input wire logic clk_sys, // clock
  input wire logic arst_n, // reset
  input wire logic scl_in, // bus clock
  input wire logic sda_in, // bus data
  input wire logic sda_out, // drive value
  input wire logic sda_oe_n, // drive enable
  input wire logic addr_pin_high, // strap
  input wire logic addr_pin_low, // strap
  input wire logic power_down_n, // pin
  input wire logic [6:0] wiper_tap, // tap
  input wire logic array_open, // open
  input wire logic wiper_grounded, // grounded
  input wire logic nv_write_pending // store busy
);
  logic [4:0] up_r; // edges since reset, saturates
  logic [31:0] pend_r; // length of the busy spell
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      up_r <= 5'h00;
    else if (up_r != 5'h1f)
      up_r <= up_r + 5'h01;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      pend_r <= 32'h0;
    else
      pend_r <= nv_write_pending ? pend_r + 32'h1 : 32'h0;
////////////////
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  chk_drive_low: assert property (!sda_oe_n |-> !sda_out)
    else $error("data pin driven high");
  chk_pin_shut: assert property ((!power_down_n)[*4] |=> array_open)
    else $error("pin did not shut down");
  chk_gnd_open: assert property (array_open == wiper_grounded)
    else $error("ground and open differ");
  chk_tap_resume: assert property ($fell(array_open) |-> $stable(wiper_tap))
    else $error("tap lost at resume");
  chk_preset_tap: assert property (up_r < 5'd15 |-> wiper_tap == 7'h40)
    else $error("preset tap wrong");
  chk_recall_tap: assert property (up_r == 5'd20 |-> wiper_tap == IVR_FACTORY[6:0])
    else $error("recall missing");
  chk_busy_len: assert property ($fell(nv_write_pending) |-> pend_r == NV_WRITE_CYC)
    else $error("busy length wrong");
  chk_busy_lock: assert property (nv_write_pending && $past(nv_write_pending)
    |-> $stable(wiper_tap))
    else $error("tap moved while busy");
  chk_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("drive changed in clock high");
  chk_busy_stop: assert property ($rose(nv_write_pending) |-> scl_in && sda_in)
    else $error("busy without stop");
  chk_ack_bound: assert property ($fell(sda_oe_n) |-> ##[1:200] sda_oe_n)
    else $error("data pin held too long");
endmodule : iwrb_chk
bind iwrb_top iwrb_chk #(.NV_WRITE_CYC(NV_WRITE_CYC), .IVR_FACTORY(IVR_FACTORY)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pin_high(addr_pin_high),
  .addr_pin_low(addr_pin_low), .power_down_n(power_down_n), .wiper_tap(wiper_tap),
  .array_open(array_open), .wiper_grounded(wiper_grounded),
  .nv_write_pending(nv_write_pending));
`default_nettype wire

// ===== verification/iwrb_master.sv
/*
  two-wire bus master model: frames, bytes and bits.
  assumes the bench resolves the pulled-up data wire.
*/
`timescale 1ns/1ps
`default_nettype none
module iwrb_master (
  input wire logic clk_sys, // pacing clock
  input wire logic sda, // resolved data wire
  output var logic scl, // bus clock, high between frames
  output var logic sda_rel // 1 releases data wire
);
  int slow = 0; // extra low-phase cycles
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
////////////////
  // data moves mid-low, sampled mid-high, away from both clock edges
  task automatic clk_bit(input logic b, output logic r);
    tick(2 + slow);
    sda_rel = b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl = 1'b0;
  endtask : clk_bit
  task automatic cond(input logic stp);
    tick(2);
    sda_rel = ~stp;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_rel = stp;
    tick(4);
    if (!stp)
      scl = 1'b0;
  endtask : cond
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                      output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(tx[i], rx[i]);
    clk_bit(ai, r);
    ak = ~r;
  endtask : xfer
////////////////
  task automatic wr(input logic [6:0] sla, input logic [7:0] ptr, dat, output logic [2:0] ak);
    logic [7:0] x;
    cond(1'b0);
    xfer({sla, 1'b0}, 1'b1, x, ak[2]);
    xfer(ptr, 1'b1, x, ak[1]);
    xfer(dat, 1'b1, x, ak[0]);
    cond(1'b1);
  endtask : wr
  task automatic rd(input logic [6:0] sla, input logic [7:0] ptr, output logic [7:0] d0, d1);
    logic a;
    cond(1'b0);
    xfer({sla, 1'b0}, 1'b1, d0, a);
    xfer(ptr, 1'b1, d0, a);
    cond(1'b0);
    xfer({sla, 1'b1}, 1'b1, d0, a);
    xfer(8'hff, 1'b0, d0, a);
    xfer(8'hff, 1'b1, d1, a);
    cond(1'b1);
  endtask : rd
endmodule : iwrb_master
`default_nettype wire

// ===== verification/tb_i2c_wiper_register_bank.sv
/*
  self-checking bench of the wiper bank through the serial bus.
  assumes the master model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_wiper_register_bank;
  logic clk_sys;
  logic arst_n;
  logic pdn_n;
  logic [1:0] pins;
  logic scl, sda_rel, sda_oe_n, sda_out, aopen, agnd, pend;
  logic [6:0] tap;
  logic [7:0] d0, d1;
  logic [2:0] ak;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam logic [6:0] SLA = {iwrb_pkg::DEV_ID_HI, 2'b10};
  // open-drain wire: pulled up unless either side pulls low
  wire logic sda = sda_rel & (sda_oe_n | sda_out);
  always #20 clk_sys = ~clk_sys;
  iwrb_top #(.NV_WRITE_CYC(2000), .IVR_FACTORY(8'h25)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_pin_high(pins[1]), .addr_pin_low(pins[0]),
    .power_down_n(pdn_n), .wiper_tap(tap), .array_open(aopen), .wiper_grounded(agnd),
    .nv_write_pending(pend));
  iwrb_master m (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_rel(sda_rel));
////////////////
  task automatic cmp(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic wrc(input logic [7:0] ptr, dat);
    m.wr(SLA, ptr, dat, ak);
    m.tick(8);
    cmp({5'h0, ak}, 8'h07);
  endtask : wrc
  task automatic rdc(input logic [7:0] ptr, exp);
    m.rd(SLA, ptr, d0, d1);
    cmp(d0, exp);
  endtask : rdc
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      end_sim();
    end
  end
////////////////
  initial
  begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    pdn_n = 1'b1;
    pins = 2'b10;
    m.tick(3);
    arst_n = 1'b1;
    cmp({1'b0, tap}, 8'h40);
    m.tick(24);
    cmp({1'b0, tap}, 8'h25);
    rdc(8'h02, 8'h40);
    rdc(8'h00, 8'h25);
    $display("test 1 done");
    for (int p = 0; p < 4; p++)
    begin
      pins = p[1:0];
      m.wr(SLA, 8'h01, 8'h33, ak);
      cmp({7'h0, ak[2]}, {7'h0, p == 2});
    end
    pins = 2'b10;
    rdc(8'h01, 8'h00);
    rdc(8'h00, 8'h25);
    $display("test 2 done");
    wrc(8'h02, 8'hc0);
    rdc(8'h02, 8'hc0);
    wrc(8'h00, 8'h7f);
    cmp({pend, tap}, 8'h7f);
    rdc(8'h00, 8'h7f);
    $display("test 3 done");
    wrc(8'h02, 8'h80);
    cmp({6'h0, aopen, agnd}, 8'h03);
    rdc(8'h00, 8'h7f);
    wrc(8'h00, 8'h2a);
    wrc(8'h02, 8'hc0);
    cmp({aopen, tap}, 8'h2a);
    pdn_n = 1'b0;
    m.tick(6);
    cmp({6'h0, aopen, agnd}, 8'h03);
    pdn_n = 1'b1;
    m.tick(6);
    cmp({aopen, tap}, 8'h2a);
    $display("test 4 done");
    wrc(8'h02, 8'h40);
    wrc(8'h00, 8'h5a);
    cmp({pend, tap}, 8'hda);
    rdc(8'h02, 8'h60);
    wrc(8'h02, 8'hc0);
    wrc(8'h00, 8'h11);
    rdc(8'h02, 8'h60);
    cmp({pend, tap}, 8'hda);
    for (int i = 0; i < 3000 && pend; i++)
      m.tick(1);
    rdc(8'h02, 8'h40);
    rdc(8'h00, 8'h5a);
    $display("test 5 done");
    m.slow = 6;
    rdc(8'h00, 8'h5a);
    cmp(d1, 8'h5a);
    m.slow = 0;
    arst_n = 1'b0;
    m.tick(3);
    arst_n = 1'b1;
    cmp({1'b0, tap}, 8'h40);
    m.tick(24);
    rdc(8'h00, 8'h25);
    $display("test 6 done");
    end_sim();
  end
endmodule : tb_i2c_wiper_register_bank
`default_nettype wire
